// ===== inc/ext_bus_pkg.sv
// Constants, types and state layout of the external bus port
// Notes on behaviour
// - Address changes in t0, holds idle, floats in reset
// - Read sampled end t2; write driven t2 through t3
// - Program/data select timed like address, high idle
// - Read/write direction in t0, high when idle
// - Write strobe low t1 to t3, data from t2
// - Read strobe low from t1, data latched at t3
// - Strobes float in reset or when not owner
// - Bus strobe low in t0, high in t2
// - Acknowledge ignored when idle, sampled each edge
// - Cycle ends two phases after acknowledge seen low
// - Longer of acknowledge and programmed waits applies
// - Acknowledge low at start gives zero waits when programmed waits are zero
// - Slave mode grants on request, floats pins
// - Accesses stall while bus granted away
// - Never grant during locked read-modify-write
// - Request removed: drop grant, resume when busy high
// - Master mode requests, waits grant and busy high
// - Request toggles between program accesses unless hold
// - Request acts as chip select with grant tied
// - Release on grant loss; grant level readable
// - Busy driven low while owner, released after
// - Mode strap latched at reset exit, software writable
package ext_bus_pkg;

  // Register byte offsets
  localparam logic [7:0] BUS_CTRL_OFS = 8'h00;
  localparam logic [7:0] OP_MODE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Field positions in bus_control_reg
  localparam int WAIT_LSB = 0;
  localparam int HOLD_POS = 4;
  localparam int GRANT_POS = 5;
  // Field position in operating_mode_reg
  localparam int MASTER_POS = 0;
  // Field positions in status register
  localparam int PHASE_LSB = 0;
  localparam int OWNER_POS = 3;
  localparam int STALL_POS = 4;

  // Reset values
  localparam logic [3:0] WAIT_RESET = 4'h0;
  localparam logic HOLD_RESET = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus cycle phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_T0 = 3'b001,
    PH_T1 = 3'b010,
    PH_T2 = 3'b011,
    PH_T3 = 3'b100
  } phase_t;

  // Pin group driven towards the external bus
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dataOut;
    logic dataOe;
    logic progSel;
    logic readDir;
    logic storeEnN;
    logic readEnN;
    logic strobeN;
    logic ctrlOe;
    logic requestN;
    logic requestOe;
    logic grantN;
    logic grantOe;
    logic busyN;
    logic busyOe;
  } pins_t;

  // Whole state of the port
  typedef struct packed {
    phase_t phase;
    pins_t pins;
    logic owner;
    logic strapDone;
    logic masterMode;
    logic [3:0] waitProg;
    logic reqHold;
    logic grantSeen;
    logic [3:0] waitCnt;
    logic ackSeen;
    logic zeroAck;
    logic curWrite;
    logic curProg;
    logic doneValid;
    logic [15:0] doneData;
    logic stalled;
    logic reqReady;
    logic awReady;
    logic wReady;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

endpackage

// ===== rtl/external_bus_port_arbiter.sv
// External memory bus controller with bus arbitration
`timescale 1ns/100ps
module external_bus_port_arbiter (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst, // Asynchronous reset, high
  // Core access port
  input wire logic reqValid, // Access pending
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic reqProgram, // 1 program space, 0 data
  input wire logic reqLocked, // Read-modify-write in progress
  input wire logic [15:0] reqAddr, // Access address
  input wire logic [15:0] reqWdata, // Write data
  output logic reqReady, // Access taken, pulse
  output logic doneValid, // Access finished, pulse
  output logic [15:0] doneData, // Read data
  output logic stalled, // Waiting for the bus
  // External bus pins
  output logic [15:0] addrOut, // Address lines
  output logic addrOe, // Address and control enable
  input wire logic [15:0] dataIn, // Data lines in
  output logic [15:0] dataOut, // Data lines out
  output logic dataOe, // Data lines enable
  output logic program_data_select, // High for program space
  output logic read_write_dir, // High read, low write
  output logic store_enable_n, // Write strobe
  output logic read_enable_n, // Read strobe
  output logic bus_strobe_n, // Bus cycle strobe
  input wire logic transfer_ack_n, // Transfer acknowledge
  input wire logic busRequestNIn, // Request pin in
  output logic busRequestNOut, // Request pin out
  output logic busRequestNOe, // Request pin enable
  input wire logic busGrantNIn, // Grant pin in
  output logic busGrantNOut, // Grant pin out
  output logic busGrantNOe, // Grant pin enable
  input wire logic busBusyNIn, // Busy pin in
  output logic busBusyNOut, // Busy pin out
  output logic busBusyNOe, // Busy pin enable
  input wire logic bus_mode_strap, // Initial bus mode
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  ext_bus_pkg::state_t st_reg; // Registered state
  ext_bus_pkg::state_t st_next; // Next state
  logic ackNow; // Acknowledge sampled low now
  logic goEnd; // Wait states satisfied
  logic startOk; // New access may begin

  // Combinational helpers
  assign ackNow = ~transfer_ack_n;
  assign goEnd = (st_reg.zeroAck && st_reg.waitProg == 4'h0) ||
    ((st_reg.ackSeen || ackNow) &&
     st_reg.waitCnt >= st_reg.waitProg);
  assign startOk = st_reg.owner && reqValid && st_reg.strapDone;

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.reqReady = 1'b0;
    st_next.doneValid = 1'b0;
    st_next.grantSeen = ~busGrantNIn;
    // Mode strap caught on the first edge after reset
    if (!st_reg.strapDone) begin
      st_next.strapDone = 1'b1;
      st_next.masterMode = bus_mode_strap;
      st_next.owner = ~bus_mode_strap;
    end
    // Bus cycle sequencer
    case (st_reg.phase)
      ext_bus_pkg::PH_IDLE: begin
        st_next.pins.readDir = 1'b1;
        st_next.pins.progSel = 1'b1;
        if (startOk && !st_reg.reqReady) begin
          st_next.phase = ext_bus_pkg::PH_T0;
          st_next.reqReady = 1'b1;
          st_next.pins.addr = reqAddr;
          st_next.pins.progSel = reqProgram;
          st_next.pins.readDir = ~reqWrite;
          st_next.pins.strobeN = 1'b0;
          st_next.pins.dataOut = reqWdata;
          st_next.curWrite = reqWrite;
          st_next.curProg = reqProgram;
          st_next.zeroAck = ackNow;
          st_next.ackSeen = 1'b0;
          st_next.waitCnt = 4'h0;
        end
      end
      ext_bus_pkg::PH_T0: begin
        st_next.phase = ext_bus_pkg::PH_T1;
        st_next.pins.storeEnN = ~st_reg.curWrite;
        st_next.pins.readEnN = st_reg.curWrite;
        st_next.ackSeen = ackNow;
      end
      ext_bus_pkg::PH_T1: begin
        st_next.phase = ext_bus_pkg::PH_T2;
        st_next.pins.dataOe = st_reg.curWrite;
        st_next.pins.strobeN = 1'b1;
        st_next.ackSeen = st_reg.ackSeen | ackNow;
      end
      ext_bus_pkg::PH_T2: begin
        // Hold t2 until both wait sources are met
        if (goEnd) begin
          st_next.phase = ext_bus_pkg::PH_T3;
          st_next.pins.storeEnN = 1'b1;
          st_next.pins.readEnN = 1'b1;
          st_next.doneData = dataIn;
        end else begin
          st_next.waitCnt = st_reg.waitCnt + 4'h1;
          st_next.ackSeen = st_reg.ackSeen | ackNow;
        end
      end
      ext_bus_pkg::PH_T3: begin
        // Acknowledge released by the far side here
        st_next.phase = ext_bus_pkg::PH_IDLE;
        st_next.pins.dataOe = 1'b0;
        st_next.doneValid = 1'b1;
        // Program fetch gives up the request between accesses
        if (st_reg.masterMode && st_reg.curProg && !st_reg.reqHold) begin
          st_next.owner = 1'b0;
        end
      end
      default: begin
        st_next.phase = ext_bus_pkg::PH_IDLE;
      end
    endcase
    // Arbitration, only between bus cycles
    if (st_reg.strapDone && st_reg.phase == ext_bus_pkg::PH_IDLE &&
        !(startOk && !st_reg.reqReady)) begin
      if (!st_reg.masterMode) begin
        st_next.pins.requestOe = 1'b0;
        st_next.pins.grantOe = 1'b1;
        if (st_reg.owner && !busRequestNIn && !reqLocked) begin
          st_next.owner = 1'b0;
          st_next.pins.grantN = 1'b0;
        end else if (!st_reg.owner && busRequestNIn) begin
          st_next.pins.grantN = 1'b1;
          if (st_reg.pins.grantN && busBusyNIn) begin
            st_next.owner = 1'b1;
          end
        end else if (!st_reg.owner && st_reg.pins.grantN &&
                     !busRequestNIn) begin
          st_next.pins.grantN = 1'b0;
        end
      end else begin
        st_next.pins.grantOe = 1'b0;
        st_next.pins.grantN = 1'b1;
        st_next.pins.requestOe = 1'b1;
        if (st_reg.owner) begin
          // Give up on grant loss or when nothing is left
          if (!st_reg.grantSeen ||
              (!reqValid && !st_reg.reqHold)) begin
            st_next.owner = 1'b0;
            st_next.pins.requestN = 1'b1;
          end
        end else if (reqValid || st_reg.reqHold) begin
          st_next.pins.requestN = 1'b0;
          if (!st_reg.pins.requestN && !busGrantNIn && busBusyNIn) begin
            st_next.owner = 1'b1;
          end
        end else begin
          st_next.pins.requestN = 1'b1;
        end
      end
    end
    // Pin enables follow bus ownership
    st_next.pins.ctrlOe = st_next.owner;
    st_next.pins.busyOe = st_next.owner;
    st_next.pins.busyN = ~st_next.owner;
    // Registered stall flag, access pending without the bus
    st_next.stalled = st_next.strapDone && reqValid && !st_next.owner;
    // AXI write address and data, either order
    if (st_reg.awReady && s_axi_awvalid) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (st_reg.wReady && s_axi_wvalid) begin
      st_next.wHeld = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
    end
    if (st_reg.awHeld && st_reg.wHeld && !st_reg.bValid) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = ext_bus_pkg::RESP_OKAY;
      case (st_reg.awAddr)
        ext_bus_pkg::BUS_CTRL_OFS: begin
          if (st_reg.wStrb[0]) begin
            st_next.waitProg = st_reg.wData[ext_bus_pkg::WAIT_LSB +: 4];
            st_next.reqHold = st_reg.wData[ext_bus_pkg::HOLD_POS];
          end
        end
        ext_bus_pkg::OP_MODE_OFS: begin
          if (st_reg.wStrb[0]) begin
            st_next.masterMode = st_reg.wData[ext_bus_pkg::MASTER_POS];
          end
        end
        ext_bus_pkg::STATUS_OFS: begin
          st_next.bResp = ext_bus_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bResp = ext_bus_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end
    st_next.awReady = !st_next.awHeld && !st_next.bValid;
    st_next.wReady = !st_next.wHeld && !st_next.bValid;
    // AXI read
    if (st_reg.arReady && s_axi_arvalid) begin
      st_next.rValid = 1'b1;
      st_next.rResp = ext_bus_pkg::RESP_OKAY;
      st_next.rData = 32'h0000_0000;
      case (s_axi_araddr)
        ext_bus_pkg::BUS_CTRL_OFS: begin
          st_next.rData[ext_bus_pkg::WAIT_LSB +: 4] = st_reg.waitProg;
          st_next.rData[ext_bus_pkg::HOLD_POS] = st_reg.reqHold;
          st_next.rData[ext_bus_pkg::GRANT_POS] = st_reg.grantSeen;
        end
        ext_bus_pkg::OP_MODE_OFS: begin
          st_next.rData[ext_bus_pkg::MASTER_POS] = st_reg.masterMode;
        end
        ext_bus_pkg::STATUS_OFS: begin
          st_next.rData[ext_bus_pkg::PHASE_LSB +: 3] = st_reg.phase;
          st_next.rData[ext_bus_pkg::OWNER_POS] = st_reg.owner;
          st_next.rData[ext_bus_pkg::STALL_POS] = reqValid && !st_reg.owner;
        end
        default: begin
          st_next.rResp = ext_bus_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
    end
    st_next.arReady = !st_next.rValid;
  end

  // State register, everything floats in reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.phase <= ext_bus_pkg::PH_IDLE;
      st_reg.pins.readDir <= 1'b1;
      st_reg.pins.progSel <= 1'b1;
      st_reg.pins.storeEnN <= 1'b1;
      st_reg.pins.readEnN <= 1'b1;
      st_reg.pins.strobeN <= 1'b1;
      st_reg.pins.requestN <= 1'b1;
      st_reg.pins.grantN <= 1'b1;
      st_reg.pins.busyN <= 1'b1;
      st_reg.waitProg <= ext_bus_pkg::WAIT_RESET;
      st_reg.reqHold <= ext_bus_pkg::HOLD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reqReady = st_reg.reqReady;
  assign doneValid = st_reg.doneValid;
  assign doneData = st_reg.doneData;
  assign stalled = st_reg.stalled;
  assign addrOut = st_reg.pins.addr;
  assign addrOe = st_reg.pins.ctrlOe;
  assign dataOut = st_reg.pins.dataOut;
  assign dataOe = st_reg.pins.dataOe;
  assign program_data_select = st_reg.pins.progSel;
  assign read_write_dir = st_reg.pins.readDir;
  assign store_enable_n = st_reg.pins.storeEnN;
  assign read_enable_n = st_reg.pins.readEnN;
  assign bus_strobe_n = st_reg.pins.strobeN;
  assign busRequestNOut = st_reg.pins.requestN;
  assign busRequestNOe = st_reg.pins.requestOe;
  assign busGrantNOut = st_reg.pins.grantN;
  assign busGrantNOe = st_reg.pins.grantOe;
  assign busBusyNOut = st_reg.pins.busyN;
  assign busBusyNOe = st_reg.pins.busyOe;
  assign s_axi_awready = st_reg.awReady;
  assign s_axi_wready = st_reg.wReady;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_arready = st_reg.arReady;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;
  assign s_axi_rvalid = st_reg.rValid;

  // Checks on the bus sequencing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence writeStart;
    st_reg.phase == ext_bus_pkg::PH_T0 && st_reg.curWrite;
  endsequence
  sequence storePulse;
    !store_enable_n ##1 !store_enable_n && dataOe;
  endsequence

  chk_addr_idle_hold: assert property (
    st_reg.phase == ext_bus_pkg::PH_IDLE &&
    $past(st_reg.phase) == ext_bus_pkg::PH_IDLE |-> $stable(addrOut))
    else $error("Address moved while idle");
  chk_data_oe_write: assert property (
    dataOe |-> st_reg.curWrite && st_reg.phase != ext_bus_pkg::PH_T0)
    else $error("Data driven outside write window");
  chk_dir_idle_high: assert property (
    $past(st_reg.phase) == ext_bus_pkg::PH_IDLE &&
    st_reg.phase == ext_bus_pkg::PH_IDLE |-> read_write_dir)
    else $error("Direction low while idle");
  chk_store_write_seq: assert property (
    writeStart |=> storePulse)
    else $error("Write strobe sequence wrong");
  chk_strobe_float_owner: assert property (
    !st_reg.owner |-> !addrOe && store_enable_n && read_enable_n)
    else $error("Pins driven while not owner");
  chk_bs_in_t0: assert property (
    st_reg.phase == ext_bus_pkg::PH_T0 |-> !bus_strobe_n ##1 !bus_strobe_n
    ##1 bus_strobe_n)
    else $error("Bus strobe timing wrong");
  chk_zero_wait_cycle: assert property (
    st_reg.phase == ext_bus_pkg::PH_T0 && st_reg.zeroAck &&
    st_reg.waitProg == 4'h0 |-> ##3 st_reg.phase == ext_bus_pkg::PH_T3)
    else $error("Zero wait cycle lengthened");
  chk_no_grant_locked: assert property (
    $fell(busGrantNOut) |-> !$past(reqLocked))
    else $error("Grant during locked access");
  chk_busy_owner_link: assert property (
    st_reg.phase != ext_bus_pkg::PH_IDLE |-> busBusyNOe && !busBusyNOut)
    else $error("Busy pin not tied to ownership");

endmodule

// ===== testbench/ext_mem_model.sv
// Static memory and acknowledge model on the far side of the bus
`timescale 1ns/100ps
module ext_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic [15:0] addrOut, // Address lines
  input wire logic [15:0] dataOut, // Device write data
  input wire logic dataOe, // Device drives data lines
  input wire logic store_enable_n, // Write strobe
  input wire logic read_enable_n, // Read strobe
  input wire logic bus_strobe_n, // Cycle strobe
  input wire logic [3:0] ackDelay, // Edges before acknowledge
  output logic [15:0] dataIn, // Resolved data lines
  output logic transfer_ack_n // Acknowledge
);
  logic [15:0] cells [256]; // Storage, low address byte
  logic [15:0] lastData = 16'h0000; // Last level seen on the lines
  logic [3:0] cnt = 4'h0; // Edges into the current cycle
  logic active; // Cycle in progress
  assign active = !bus_strobe_n || !read_enable_n || !store_enable_n;
  // Zero delay holds it low; otherwise released in t3
  assign transfer_ack_n = (ackDelay != 4'h0) && (!active || cnt < ackDelay);
  // Device data, memory, else a pattern that changes every cycle
  always_comb begin
    if (dataOe) begin
      dataIn = dataOut;
    end else if (!read_enable_n) begin
      dataIn = cells[addrOut[7:0]];
    end else begin
      dataIn = ~lastData;
    end
  end
  // Cycle counter and write capture
  always @(posedge clk_sys) begin
    lastData <= dataIn;
    if (!active) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
    if (!store_enable_n && dataOe) begin
      cells[addrOut[7:0]] <= dataOut;
    end
  end
endmodule

// ===== testbench/external_bus_port_arbiter_tb_top.sv
// Self-checking bench of the external bus port
`timescale 1ns/100ps
module external_bus_port_arbiter_tb_top;
  // One expected core access
  typedef struct packed {
    logic wr; // Write access
    logic prog; // Program space
    logic [15:0] addr; // Address
    logic [15:0] data; // Expected read data
    logic [7:0] lat; // Cycles from taken to done
  } note_t;
  logic clk_sys = 1'b0; // System clock
  logic rst = 1'b1; // Reset
  logic reqValid = 1'b0, reqWrite = 1'b0, reqProgram = 1'b0; // Request
  logic reqLocked = 1'b0; // Locked sequence
  logic [15:0] reqAddr = 16'h0000, reqWdata = 16'h0000; // Payload
  logic reqReady, doneValid, stalled, addrOe, dataOe; // Core results
  logic [15:0] doneData, addrOut, dataOut, dataIn; // Data paths
  logic program_data_select, read_write_dir, store_enable_n; // Control
  logic read_enable_n, bus_strobe_n, transfer_ack_n; // Strobes
  logic busRequestNOut, busRequestNOe, busGrantNOut, busGrantNOe; // Arbiter
  logic busBusyNOut, busBusyNOe; // Busy pin
  logic otherReqN = 1'b1, otherGrantN = 1'b1, otherBusyN = 1'b1; // Other
  logic [3:0] ackDelay = 4'h0; // Memory acknowledge delay
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // Addresses
  logic [31:0] s_axi_wdata = 32'h00000000; // Write data
  logic [3:0] s_axi_wstrb = 4'hF; // All lanes
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // Read channel
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid; // Read valid
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic [31:0] s_axi_rdata; // Read data
  logic bus_mode_strap = 1'b0; // Slave after power-on
  // Pin levels resolved from both parties
  wire logic busRequestNIn = busRequestNOe ? busRequestNOut : otherReqN;
  wire logic busGrantNIn = busGrantNOe ? busGrantNOut : otherGrantN;
  wire logic busBusyNIn = busBusyNOe ? busBusyNOut : otherBusyN;
  int mismatches = 0, num_checks = 0, cyc = 0, t0 = 0; // Counters
  note_t q[$]; // Pending access notes
  external_bus_port_arbiter DUT (
    .clk_sys, .rst, .reqValid, .reqWrite, .reqProgram, .reqLocked, .reqAddr,
    .reqWdata, .reqReady, .doneValid, .doneData, .stalled, .addrOut, .addrOe,
    .dataIn, .dataOut, .dataOe, .program_data_select, .read_write_dir,
    .store_enable_n, .read_enable_n, .bus_strobe_n, .transfer_ack_n,
    .busRequestNIn, .busRequestNOut, .busRequestNOe, .busGrantNIn,
    .busGrantNOut, .busGrantNOe, .busBusyNIn, .busBusyNOut, .busBusyNOe,
    .bus_mode_strap, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ext_mem_model farSide (
    .clk_sys, .addrOut, .dataOut, .dataOe, .store_enable_n, .read_enable_n,
    .bus_strobe_n, .ackDelay, .dataIn, .transfer_ack_n
  );
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Counts, verdict, end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // Expected length: longer of programmed and acknowledge waits
  function automatic int latOf(input int p, input int d);
    return 4 + ((d - 2 > p) ? d - 2 : p);
  endfunction
  // Register write, both channels offered together
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === ext_bus_pkg::RESP_OKAY, "write response");
  endtask
  // Register read with masked compare
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk((s_axi_rdata & m) === e && s_axi_rresp === er, "register read");
  endtask
  // Core access: note first, hold request until taken, await done
  task automatic acc(input logic w, input logic p, input logic [15:0] a,
                     input logic [15:0] d, input int lat);
    int n;
    n = 0;
    @(posedge clk_sys);
    q.push_back('{w, p, a, d, 8'(lat)});
    reqWrite <= w;
    reqProgram <= p;
    reqAddr <= a;
    reqWdata <= d;
    reqValid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (reqReady !== 1'b1 && n < 200);
    reqValid <= 1'b0;
    while (doneValid !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 400, "access did not finish");
    repeat (2) @(posedge clk_sys);
  endtask
  // Watcher: phase pins against the oldest note, completion pops it
  always @(posedge clk_sys) begin
    note_t nt;
    if (q.size() == 0 && addrOe === 1'b1) begin
      chk(program_data_select === 1'b1 && read_write_dir === 1'b1, "idle");
    end
    if (q.size() > 0 && reqReady === 1'b1) begin
      t0 = cyc;
      chk(addrOut === q[0].addr, "address");
      chk(program_data_select === q[0].prog, "space select");
      chk(read_write_dir === !q[0].wr, "direction");
      chk(bus_strobe_n === 1'b0, "bus strobe t0");
      chk(busBusyNOe === 1'b1 && busBusyNOut === 1'b0, "busy");
      if (busRequestNOe === 1'b1) chk(busRequestNOut === 1'b0, "request");
    end
    if (q.size() > 0 && cyc == t0 + 1) begin
      chk(read_enable_n === q[0].wr, "read strobe t1");
      chk(store_enable_n === !q[0].wr, "write strobe t1");
    end
    if (q.size() > 0 && cyc == t0 + 2) begin
      chk(bus_strobe_n === 1'b1, "bus strobe t2");
      chk(dataOe === q[0].wr, "data drive t2");
    end
    if (doneValid === 1'b1) begin
      chk(q.size() > 0, "unexpected completion");
      if (q.size() > 0) begin
        nt = q.pop_front();
        chk(cyc - t0 == int'(nt.lat), "cycle length");
        if (!nt.wr) chk(doneData === nt.data, "read data");
      end
    end
  end
  // Main sequence
  initial begin
    int pv[3] = '{0, 1, 3};
    int dv[4] = '{0, 1, 3, 5};
    logic [15:0] a, d;
    void'($urandom(32'h66227713));
    repeat (6) @(posedge clk_sys);
    chk(addrOe === 1'b0 && dataOe === 1'b0 && busRequestNOe === 1'b0 &&
        busGrantNOe === 1'b0 && busBusyNOe === 1'b0, "float in reset");
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdChk(ext_bus_pkg::OP_MODE_OFS, 32'h1, 32'h0, ext_bus_pkg::RESP_OKAY);
    rdChk(ext_bus_pkg::STATUS_OFS, 32'h8, 32'h8, ext_bus_pkg::RESP_OKAY);
    rdChk(8'h0C, 32'hFFFFFFFF, 32'h0, ext_bus_pkg::RESP_SLVERR);
    $display("test registers done");
    // Every programmed wait with every acknowledge delay
    for (int i = 0; i < 12; i++) begin
      axiWr(ext_bus_pkg::BUS_CTRL_OFS, 32'(pv[i % 3]));
      rdChk(ext_bus_pkg::BUS_CTRL_OFS, 32'hF, 32'(pv[i % 3]),
            ext_bus_pkg::RESP_OKAY);
      ackDelay <= 4'(dv[i / 3]);
      a = {8'($urandom), 8'(i)};
      d = 16'($urandom);
      acc(1'b1, i[0], a, d, latOf(pv[i % 3], dv[i / 3]));
      acc(1'b0, i[0], a, d, latOf(pv[i % 3], dv[i / 3]));
    end
    axiWr(ext_bus_pkg::BUS_CTRL_OFS, 32'h0);
    ackDelay <= 4'h0;
    $display("test wait states done");
    // Slave mode: locked sequence, grant, stall, return
    reqLocked <= 1'b1;
    otherReqN <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(!(busGrantNOe === 1'b1 && busGrantNOut === 1'b0), "locked");
    reqLocked <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(busGrantNOe === 1'b1 && busGrantNOut === 1'b0, "grant");
    chk(addrOe === 1'b0 && dataOe === 1'b0 && busBusyNOe === 1'b0,
        "pins released");
    otherBusyN <= 1'b0;
    fork
      acc(1'b0, 1'b0, a, d, 4);
      begin
        repeat (6) @(posedge clk_sys);
        chk(stalled === 1'b1 && addrOe === 1'b0, "stall");
        otherReqN <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(busGrantNOut === 1'b1 && addrOe === 1'b0, "wait busy");
        otherBusyN <= 1'b1;
      end
    join
    $display("test slave arbitration done");
    // Master mode: toggle, request hold, grant loss, regrant
    otherGrantN <= 1'b0;
    axiWr(ext_bus_pkg::OP_MODE_OFS, 32'h1);
    rdChk(ext_bus_pkg::OP_MODE_OFS, 32'h1, 32'h1, ext_bus_pkg::RESP_OKAY);
    rdChk(ext_bus_pkg::BUS_CTRL_OFS, 32'h20, 32'h20,
          ext_bus_pkg::RESP_OKAY);
    a = 16'($urandom);
    d = 16'($urandom);
    acc(1'b1, 1'b1, a, d, 4);
    chk(busRequestNOe === 1'b1 && busRequestNOut === 1'b1, "toggle");
    axiWr(ext_bus_pkg::BUS_CTRL_OFS, 32'h10);
    acc(1'b0, 1'b1, a, d, 4);
    chk(busRequestNOut === 1'b0, "request hold");
    otherGrantN <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(addrOe === 1'b0 && busBusyNOe === 1'b0, "release");
    rdChk(ext_bus_pkg::BUS_CTRL_OFS, 32'h20, 32'h0,
          ext_bus_pkg::RESP_OKAY);
    fork
      acc(1'b0, 1'b0, a, d, 4);
      begin
        repeat (6) @(posedge clk_sys);
        chk(stalled === 1'b1, "wait grant");
        otherGrantN <= 1'b0;
      end
    join
    // Reset again with the strap high: master mode latched
    bus_mode_strap <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdChk(ext_bus_pkg::OP_MODE_OFS, 32'h1, 32'h1, ext_bus_pkg::RESP_OKAY);
    $display("test master arbitration done");
    conclude();
  end
endmodule
